// ==== tcc_block.sv ====
// compare/capture circuits of one 16-bit timer channel with apb registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_block #(
   parameter int N_CC = 2
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // counter block status
   input tcc_pkg::tcc_cnt_t cnt,
   // shared pins and trigger sources
   input wire logic [N_CC-1:0] cap_pin_in,
   input wire logic [N_CC-1:0] ext_trig_in,
   input wire logic [N_CC-1:0] tout_wave_in,
   output logic [N_CC-1:0] timer_output_pin,
   output logic [N_CC-1:0] pin_oe_n,
   // waveform generator events
   output logic [N_CC-1:0] match,
   output logic max_evt,
   output logic zero_evt,
   // dma requests and accepts
   output logic [N_CC-1:0] cc_dma_req,
   input wire logic [N_CC-1:0] cc_dma_ack,
   output logic mz_dma_req,
   input wire logic mz_dma_ack,
   // interrupt request
   output logic irq
);
   import tcc_pkg::*;

   // circuit count must be 2, 4 or 6
   if (N_CC != 2 && N_CC != 4 && N_CC != 6) begin : g_bad_count
      $error("tcc_block: N_CC must be 2, 4 or 6");
   end

   // state
   logic [15:0] maxv_q, maxv_d;
   logic max_flag_q, max_flag_d;
   logic zero_flag_q, zero_flag_d;
   logic [N_CC-1:0] cc_flag_q, cc_flag_d;
   logic [N_CC-1:0] ow_flag_q, ow_flag_d;
   logic [31:0] irqen_q, irqen_d;
   logic [31:0] dmaen_q, dmaen_d;
   tcc_ctl_t [N_CC-1:0] ctl_q, ctl_d;
   logic [N_CC-1:0][15:0] data_q, data_d;
   logic [N_CC-1:0][15:0] buf_q, buf_d;
   logic [N_CC-1:0] prev_q, smp_q, src_sel;
   logic [N_CC-1:0] cmp_evt, cap_evt;
   logic [31:0] rd_data;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // apb decode; a write lands only at the edge that completes the access
   logic acc_done, wr_en, setup, addr_ok;
   logic [7:0] cc_rel;
   logic [3:0] cc_idx;
   logic cc_area;
   assign setup = psel && !penable;
   assign acc_done = psel && penable && pready_q;
   assign wr_en = acc_done && pwrite;
   assign cc_rel = paddr - `TCC_OFF_CC_BASE;
   assign cc_idx = cc_rel[6:3];
   // bit 7 of the circuit offset must be clear, or high offsets would alias low circuits
   assign cc_area = (paddr >= `TCC_OFF_CC_BASE) && !cc_rel[7] && (32'(cc_idx) < N_CC) &&
                    (paddr[1:0] == 2'h0);
   assign addr_ok = cc_area || (paddr == `TCC_OFF_MAXV) || (paddr == `TCC_OFF_FLAGS) ||
                    (paddr == `TCC_OFF_IRQEN) || (paddr == `TCC_OFF_DMAEN);

   // true when the completing write targets this offset; the bus terms are arguments
   // so that every continuous assignment calling it re-evaluates when they move
   function automatic logic wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] off);
      wr_hit = en && (addr == off);
   endfunction

   // counter events, only while counting
   logic cnt_tick, at_max, at_zero;
   assign cnt_tick = ce && cnt.run && cnt.tick;
   assign at_max = cnt_tick && (cnt.value == maxv_q);
   assign at_zero = cnt_tick && (cnt.value == 16'h0000);

   // max/zero flags; hardware set wins over a software or dma clear
   logic mz_dma_down, flg_wr;
   assign flg_wr = wr_hit(wr_en, paddr, `TCC_OFF_FLAGS);
   // follows the live count mode, so a mode change retargets a pending reload request
   assign mz_dma_down = (cnt.mode == TCC_CNT_DOWN);
   assign max_flag_d = at_max || (max_flag_q && !(flg_wr && pwdata[`TCC_FLG_MAX]) &&
                       !(mz_dma_ack && mz_dma_req && !mz_dma_down));
   assign zero_flag_d = at_zero || (zero_flag_q && !(flg_wr && pwdata[`TCC_FLG_ZERO]) &&
                        !(mz_dma_ack && mz_dma_req && mz_dma_down));
   assign maxv_d = wr_hit(wr_en, paddr, `TCC_OFF_MAXV) ? pwdata[15:0] : maxv_q;
   assign irqen_d = wr_hit(wr_en, paddr, `TCC_OFF_IRQEN) ? pwdata : irqen_q;
   assign dmaen_d = wr_hit(wr_en, paddr, `TCC_OFF_DMAEN) ? pwdata : dmaen_q;

   // one generated slice per circuit, each set up on its own
   for (genvar m = 0; m < N_CC; m++) begin : g_cc
      logic ctl_wr, data_wr, rise, fall, edge_hit, buf_load;
      logic [7:0] base;
      assign base = 8'(`TCC_OFF_CC_BASE + m * `TCC_CC_STRIDE);
      // offsets match exactly; the gap inside the stride decodes to nothing
      assign ctl_wr = wr_hit(wr_en, paddr, base);
      assign data_wr = wr_hit(wr_en, paddr, 8'(base + `TCC_OFF_CC_DATA)) && !ctl_q[m].cc_mode_select;
      assign ctl_d[m] = ctl_wr ? tcc_ctl_t'(pwdata[8:0]) : ctl_q[m];

      // trigger source: pin, external trigger, or fixed levels for software edges
      assign src_sel[m] = (ctl_q[m].capture_source_select == 2'h0) ? cap_pin_in[m] :
                          (ctl_q[m].capture_source_select == 2'h1) ? ext_trig_in[m] :
                          ctl_q[m].capture_source_select[0];

      // sync mode compares count-clock samples, so pulses between ticks vanish;
      // async mode compares every pclk and keeps short pulses
      assign rise = ctl_q[m].sync_capture_select ? (cnt_tick && src_sel[m] && !smp_q[m]) :
                    (src_sel[m] && !prev_q[m]);
      assign fall = ctl_q[m].sync_capture_select ? (cnt_tick && !src_sel[m] && smp_q[m]) :
                    (!src_sel[m] && prev_q[m]);
      assign edge_hit = (ctl_q[m].capture_edge_select == `TCC_EDGE_RISE && rise) ||
                        (ctl_q[m].capture_edge_select == `TCC_EDGE_FALL && fall) ||
                        (ctl_q[m].capture_edge_select == `TCC_EDGE_BOTH && (rise || fall));
      assign cap_evt[m] = ce && cnt.run && ctl_q[m].cc_mode_select && edge_hit;

      // match on the count clock that brings counter onto the buffer value
      assign cmp_evt[m] = cnt_tick && !ctl_q[m].cc_mode_select && (cnt.value == buf_q[m]);

      // buffer reload, every cycle in direct mode or timed to the count sequence
      assign buf_load = (ctl_q[m].compare_buffer_load_mode == `TCC_BUF_DIRECT) ||
                        (ctl_q[m].compare_buffer_load_mode == `TCC_BUF_AT_ZERO && at_zero) ||
                        (ctl_q[m].compare_buffer_load_mode == `TCC_BUF_AT_MAX && at_max) ||
                        (ctl_q[m].compare_buffer_load_mode[2:1] != 2'h0 &&
                         ctl_q[m].compare_buffer_load_mode != `TCC_BUF_AT_MAX && (at_zero || at_max));
      assign buf_d[m] = buf_load ? data_q[m] : buf_q[m];

      // capture latches the counter; compare data written only in comparator mode
      assign data_d[m] = cap_evt[m] ? cnt.value : (data_wr ? pwdata[15:0] : data_q[m]);

      // flag set wins over a write-1 or dma-accept clear
      assign cc_flag_d[m] = cmp_evt[m] || cap_evt[m] ||
                            (cc_flag_q[m] && !(flg_wr && pwdata[`TCC_FLG_CC + m]) &&
                             !(cc_dma_ack[m] && cc_dma_req[m]));
      assign ow_flag_d[m] = (cap_evt[m] && cc_flag_q[m]) ||
                            (ow_flag_q[m] && !(flg_wr && pwdata[`TCC_FLG_OW + m]));
   end

   // read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      if (paddr == `TCC_OFF_MAXV) begin
         rd_data[15:0] = maxv_q;
      end else if (paddr == `TCC_OFF_FLAGS) begin
         rd_data[`TCC_FLG_MAX] = max_flag_q;
         rd_data[`TCC_FLG_ZERO] = zero_flag_q;
         rd_data[`TCC_FLG_CC +: N_CC] = cc_flag_q;
         rd_data[`TCC_FLG_OW +: N_CC] = ow_flag_q;
      end else if (paddr == `TCC_OFF_IRQEN) begin
         rd_data = irqen_q;
      end else if (paddr == `TCC_OFF_DMAEN) begin
         rd_data = dmaen_q;
      end else if (cc_area) begin
         if (cc_rel[2]) begin
            rd_data[15:0] = data_q[cc_idx];
         end else begin
            rd_data[8:0] = ctl_q[cc_idx];
         end
      end
   end

   // apb response: one access cycle, read data captured in setup
   // a setup presented while ce is low is not seen, so the master must keep ce high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q <= setup;
         if (setup) begin
            prdata_q <= rd_data;
            pslverr_q <= !addr_ok;
         end
      end
   end

   // configuration and flag state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maxv_q <= `TCC_RST_MAXV;
         irqen_q <= 32'h0000_0000;
         dmaen_q <= 32'h0000_0000;
         max_flag_q <= 1'b0;
         zero_flag_q <= 1'b0;
         cc_flag_q <= '0;
         ow_flag_q <= '0;
         ctl_q <= '0;
      end else if (ce) begin
         maxv_q <= maxv_d;
         irqen_q <= irqen_d;
         dmaen_q <= dmaen_d;
         max_flag_q <= max_flag_d;
         zero_flag_q <= zero_flag_d;
         cc_flag_q <= cc_flag_d;
         ow_flag_q <= ow_flag_d;
         ctl_q <= ctl_d;
      end
   end

   // per-circuit data, buffers and trigger history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= '0;
         buf_q <= '0;
         prev_q <= '0;
         smp_q <= '0;
      end else if (ce) begin
         data_q <= data_d;
         buf_q <= buf_d;
         prev_q <= src_sel;
         if (cnt_tick) begin
            smp_q <= src_sel;
         end
      end
   end

   // registered outputs; the waveform generator sees one-cycle event pulses
   logic [N_CC-1:0] match_q, cc_dma_req_q, pin_q, oe_n_q;
   logic max_evt_q, zero_evt_q, mz_dma_req_q, irq_q;
   logic [31:0] flag_vec;
   // unused positions stay zero so a wide enable word cannot raise a phantom request
   assign flag_vec = {{(16 - N_CC){1'b0}}, ow_flag_q, {(8 - N_CC){1'b0}}, cc_flag_q,
                      6'h00, zero_flag_q, max_flag_q};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_q <= '0;
         max_evt_q <= 1'b0;
         zero_evt_q <= 1'b0;
         cc_dma_req_q <= '0;
         mz_dma_req_q <= 1'b0;
         irq_q <= 1'b0;
         pin_q <= '0;
         oe_n_q <= '1;
      end else if (ce) begin
         match_q <= cmp_evt;
         max_evt_q <= at_max;
         zero_evt_q <= at_zero;
         cc_dma_req_q <= cc_flag_d & dmaen_q[`TCC_DMA_CC +: N_CC];
         mz_dma_req_q <= dmaen_q[`TCC_DMA_MZ] && (mz_dma_down ? zero_flag_d : max_flag_d);
         irq_q <= |(flag_vec & irqen_q);
         pin_q <= tout_wave_in;
         for (int m = 0; m < N_CC; m++) begin
            oe_n_q[m] <= ctl_d[m].cc_mode_select;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign match = match_q;
   assign max_evt = max_evt_q;
   assign zero_evt = zero_evt_q;
   assign cc_dma_req = cc_dma_req_q;
   assign mz_dma_req = mz_dma_req_q;
   assign irq = irq_q;
   assign timer_output_pin = pin_q;
   assign pin_oe_n = oe_n_q;
endmodule

// ==== tcc_consts.svh ====
// register offsets, field positions, reset values and timing counts for the capture/compare block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register byte offsets
`define TCC_OFF_MAXV 8'h00
`define TCC_OFF_FLAGS 8'h04
`define TCC_OFF_IRQEN 8'h08
`define TCC_OFF_DMAEN 8'h0C
`define TCC_OFF_CC_BASE 8'h10
`define TCC_CC_STRIDE 8'h08
`define TCC_OFF_CC_DATA 8'h04

// event flag register bit positions
`define TCC_FLG_MAX 0
`define TCC_FLG_ZERO 1
`define TCC_FLG_CC 8
`define TCC_FLG_OW 16

// dma enable register bit positions
`define TCC_DMA_CC 0
`define TCC_DMA_MZ 16

// capture edge select codes
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3

// compare buffer load modes
`define TCC_BUF_DIRECT 3'h0
`define TCC_BUF_AT_ZERO 3'h1
`define TCC_BUF_AT_MAX 3'h2

// reset values
`define TCC_RST_MAXV 16'hFFFF
`define TCC_RST_DATA 16'h0000

// apb answers after one access cycle
`define TCC_APB_WAIT 1
`endif

// ==== tcc_pkg.sv ====
// types shared by the capture/compare block
package tcc_pkg;
   // counting mode reported by the counter block
   typedef enum logic [1:0] {
      TCC_CNT_UP,
      TCC_CNT_DOWN,
      TCC_CNT_UPDOWN
   } tcc_cnt_mode_t;

   // per-circuit control register
   typedef struct packed {
      logic sync_capture_select;
      logic [1:0] capture_edge_select;
      logic [1:0] capture_source_select;
      logic [2:0] compare_buffer_load_mode;
      logic cc_mode_select;
   } tcc_ctl_t;

   // counter block status feeding the circuits
   typedef struct packed {
      logic run;
      logic tick;
      tcc_cnt_mode_t mode;
      logic [15:0] value;
   } tcc_cnt_t;
endpackage

// ==== tcc_block_assertions.sv ====
// concurrent checks on the capture/compare block ports
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_block_assertions #(parameter int N_CC = 2) (
   // clock and reset
   input logic pclk,
   input logic presetn,
   input logic ce,
   // apb
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic pready,
   // counter and pins
   input tcc_pkg::tcc_cnt_t cnt,
   input logic [N_CC-1:0] tout_wave_in,
   input logic [N_CC-1:0] timer_output_pin,
   input logic [N_CC-1:0] pin_oe_n,
   // events and requests
   input logic [N_CC-1:0] match,
   input logic max_evt,
   input logic zero_evt,
   input logic [N_CC-1:0] cc_dma_req,
   input logic [N_CC-1:0] cc_dma_ack,
   input logic mz_dma_req,
   input logic irq
);
   import tcc_pkg::*;
   logic [15:0] max_q;
   logic [31:0] ien_q;
   logic [31:0] den_q;
   wire wr_ok = psel && penable && pready && pwrite && ce;
   wire cnt_ev = cnt.run && cnt.tick && ce;
   // shadow of the settings, so events can be tied to their cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         max_q <= `TCC_RST_MAXV;
         ien_q <= 32'h0;
         den_q <= 32'h0;
      end else if (wr_ok) begin
         if (paddr == `TCC_OFF_MAXV) max_q <= pwdata[15:0];
         if (paddr == `TCC_OFF_IRQEN) ien_q <= pwdata;
         if (paddr == `TCC_OFF_DMAEN) den_q <= pwdata;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pready_next: assert property (psel && !penable && ce |=> pready) else $error("no answer after setup");
   a_match_cause: assert property (match[0] |-> $past(cnt_ev)) else $error("match without count");
   a_max_event: assert property (cnt_ev && cnt.value == max_q |=> max_evt) else $error("max event missing");
   a_zero_event: assert property (cnt_ev && cnt.value == 16'h0000 |=> zero_evt) else $error("zero missing");
   a_evt_quiet: assert property (ce && !cnt_ev |=> !max_evt && !zero_evt) else $error("event while idle");
   a_ccreq_en: assert property (cc_dma_req[0] |-> den_q[`TCC_DMA_CC] || $past(den_q[`TCC_DMA_CC]))
      else $error("cc request while off");
   a_mzreq_en: assert property (mz_dma_req |-> den_q[`TCC_DMA_MZ] || $past(den_q[`TCC_DMA_MZ]))
      else $error("mz request while off");
   a_ack_drops: assert property (ce && cc_dma_ack[0] && cc_dma_req[0] && !cnt_ev |=> !cc_dma_req[0])
      else $error("request held after accept");
   a_irq_masked: assert property (ien_q == 0 && $past(ien_q == 0) && $past(ien_q == 0, 2) |-> !irq)
      else $error("irq while masked");
   a_tout_follow: assert property (!pin_oe_n[0] && $past(!pin_oe_n[0]) && $past(ce) |->
      timer_output_pin[0] == $past(tout_wave_in[0])) else $error("pin not waveform");
   c_match: cover property (match[0]);
   c_accept: cover property (cc_dma_req[0] && cc_dma_ack[0]);
   c_irq: cover property (irq);
endmodule
bind tcc_block tcc_block_assertions #(.N_CC(N_CC)) u_tcc_block_assertions (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .cnt(cnt), .tout_wave_in(tout_wave_in), .timer_output_pin(timer_output_pin), .pin_oe_n(pin_oe_n),
   .match(match), .max_evt(max_evt), .zero_evt(zero_evt), .cc_dma_req(cc_dma_req),
   .cc_dma_ack(cc_dma_ack), .mz_dma_req(mz_dma_req), .irq(irq));

// ==== tcc_dma_model.sv ====
// dma controller stand-in answering transfer requests
`timescale 1ns/1ps
module tcc_dma_model #(parameter int N_CC = 2) (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // high for a slow controller
   input logic slow,
   // requests and accepts
   input logic [N_CC-1:0] cc_dma_req,
   output logic [N_CC-1:0] cc_dma_ack,
   input logic mz_dma_req,
   output logic mz_dma_ack
);
   logic [1:0] wait_q;
   wire pend = (|cc_dma_req) || mz_dma_req;
   wire go = pend && (wait_q >= {slow, slow});
   // arbitration wait, restarted after each accept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 2'h0;
      end else begin
         wait_q <= (go || !pend) ? 2'h0 : wait_q + 2'h1;
      end
   end
   // channels leave reset programmed and enabled
   // one halfword per accept, arbitrated each transfer; no re-accept of a dying request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_dma_ack <= '0;
         mz_dma_ack <= 1'b0;
      end else begin
         cc_dma_ack <= go ? cc_dma_req & ~cc_dma_ack : '0;
         mz_dma_ack <= go && mz_dma_req && !mz_dma_ack;
      end
   end
endmodule

// ==== tb.sv ====
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "tcc_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb;
   import tcc_pkg::*;
   localparam logic [7:0] FL = `TCC_OFF_FLAGS;
   localparam logic [7:0] CD0 = `TCC_OFF_CC_BASE + `TCC_OFF_CC_DATA;
   localparam logic [7:0] CC1 = `TCC_OFF_CC_BASE + `TCC_CC_STRIDE;
   localparam logic [7:0] CD1 = CC1 + `TCC_OFF_CC_DATA;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, max_evt, zero_evt, mz_dma_req, mz_dma_ack, irq;
   tcc_cnt_t cnt = '0;
   logic [1:0] cap_pin_in = 0, ext_trig_in = 0, tout_wave_in = 0;
   logic [1:0] timer_output_pin, pin_oe_n, match, cc_dma_req, cc_dma_ack;
   logic [15:0] last = `TCC_RST_DATA;
   logic [32:0] exp_q[$];
   int err_count = 0, checked = 0, seed = 80117, mx, cc, v, n;
   always #4 pclk = ~pclk;
   tcc_block #(.N_CC(2)) u_tcc_block (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cnt(cnt), .cap_pin_in(cap_pin_in), .ext_trig_in(ext_trig_in), .tout_wave_in(tout_wave_in),
      .timer_output_pin(timer_output_pin), .pin_oe_n(pin_oe_n), .match(match), .max_evt(max_evt),
      .zero_evt(zero_evt), .cc_dma_req(cc_dma_req), .cc_dma_ack(cc_dma_ack), .mz_dma_req(mz_dma_req),
      .mz_dma_ack(mz_dma_ack), .irq(irq));
   tcc_dma_model #(.N_CC(2)) u_tcc_dma_model (.pclk(pclk), .presetn(presetn), .slow(slow),
      .cc_dma_req(cc_dma_req), .cc_dma_ack(cc_dma_ack), .mz_dma_req(mz_dma_req), .mz_dma_ack(mz_dma_ack));
   // waveform input wanders so the pin copy is really exercised
   always @(posedge pclk) tout_wave_in <= 2'($random(seed));
   // read answers are compared with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK({pslverr, prdata}, exp_q.pop_front())
      end
   end
   task automatic stop_test();
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         err_count++;
         stop_test();
      end
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic x = 1'b0);
      exp_q.push_back({x, e});
      apb(1'b0, a, 32'h0);
   endtask
   // one count clock; outputs looked at once the event edge has landed
   task automatic tick(input logic [15:0] val, input tcc_cnt_mode_t md);
      logic [1:0] tw;
      @(posedge pclk);
      cnt <= '{run: 1'b1, tick: 1'b1, mode: md, value: val};
      @(posedge pclk);
      tw = tout_wave_in;
      cnt.tick <= 1'b0;
      #1;
      `CHK(timer_output_pin, tw)
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TCC_OFF_MAXV, 32'h0000FFFF);
      wr(8'hF0, 32'hFFFFFFFF);
      rd(8'hF0, 32'h0, 1'b1);
      // compare timing over a full cycle, both directions; circuit 1 sits at zero
      mx = 4 + ($random(seed) & 7);
      cc = ($random(seed) & 32'hFF) % (mx + 1);
      wr(`TCC_OFF_MAXV, mx);
      wr(CD0, cc);
      for (int dn = 0; dn < 2; dn++) begin
         for (int i = 0; i <= mx; i++) begin
            v = dn ? mx - i : i;
            tick(v[15:0], dn ? TCC_CNT_DOWN : TCC_CNT_UP);
            `CHK({match, max_evt, zero_evt}, {v == 0, v == cc, v == mx, v == 0})
         end
      end
      rd(FL, 32'h00000303);
      wr(FL, 32'h00000303);
      rd(FL, 32'h0);
      // buffer loads only at zero
      wr(`TCC_OFF_CC_BASE, {28'h0, `TCC_BUF_AT_ZERO, 1'b0});
      wr(CD0, 32'h0000FFFF);
      tick(16'hFFFF, TCC_CNT_UP);
      `CHK(match[0], 1'b0)
      tick(16'h0000, TCC_CNT_UP);
      tick(16'hFFFF, TCC_CNT_UP);
      `CHK(match[0], 1'b1)
      wr(FL, 32'h00000303);
      // dma requests with a slow controller
      slow <= 1'b1;
      wr(`TCC_OFF_DMAEN, 32'h00010001);
      tick(16'hFFFF, TCC_CNT_DOWN);
      `CHK(cc_dma_req[0], 1'b1)
      tick(mx[15:0], TCC_CNT_DOWN);
      `CHK(mz_dma_req, 1'b0)
      tick(16'h0000, TCC_CNT_DOWN);
      `CHK(mz_dma_req, 1'b1)
      for (n = 0; n < 20 && (cc_dma_req[0] === 1'b1 || mz_dma_req === 1'b1); n++) @(posedge pclk);
      if (n == 20) begin
         err_count++;
         stop_test();
      end
      rd(FL, 32'h00000201);
      wr(`TCC_OFF_DMAEN, 32'h0);
      wr(FL, 32'h00000303);
      // interrupt for the zero flag only, its dma now off
      wr(`TCC_OFF_IRQEN, 32'h00000002);
      tick(mx[15:0], TCC_CNT_UP);
      @(posedge pclk);
      #1 `CHK(irq, 1'b0)
      tick(16'h0000, TCC_CNT_UP);
      @(posedge pclk);
      #1 `CHK(irq, 1'b1)
      wr(`TCC_OFF_IRQEN, 32'h0);
      wr(FL, 32'h00000303);
      // software edges on circuit 1 for every edge code
      for (int e = 0; e < 4; e++) begin
         v = $random(seed) & 32'hFFFF;
         cnt <= '{run: 1'b1, tick: 1'b0, mode: TCC_CNT_UP, value: v[15:0]};
         wr(CC1, {23'h0, 1'b0, e[1:0], 2'h2, 3'h0, 1'b1});
         wr(CC1, {23'h0, 1'b0, e[1:0], 2'h3, 3'h0, 1'b1});
         wr(CC1, {23'h0, 1'b0, e[1:0], 2'h2, 3'h0, 1'b1});
         n = e[0] + e[1];
         if (n > 0) last = v[15:0];
         wr(CD1, ~v);
         rd(CD1, {16'h0, last});
         rd(FL, {14'h0, n > 1, 7'h0, n > 0, 9'h0});
         wr(FL, 32'h00020200);
      end
      `CHK(pin_oe_n, 2'b10)
      // short pin pulse between count clocks: caught only without sync
      for (int s = 0; s < 2; s++) begin
         wr(CC1, {23'h0, s[0], 2'h1, 2'h0, 3'h0, 1'b1});
         @(posedge pclk);
         cap_pin_in <= 2'b10;
         @(posedge pclk);
         cap_pin_in <= 2'b00;
         tick(16'h1234, TCC_CNT_UP);
         rd(FL, {22'h0, s == 0, 9'h0});
         wr(FL, 32'h00020200);
      end
      @(posedge pclk);
      cap_pin_in <= 2'b10;
      tick(16'h4321, TCC_CNT_UP);
      rd(CD1, 32'h00004321);
      // clock enable low freezes the block: a zero count edge leaves no trace
      ce <= 1'b0;
      @(posedge pclk);
      cnt <= '{run: 1'b1, tick: 1'b1, mode: TCC_CNT_UP, value: 16'h0000};
      @(posedge pclk);
      {ce, cnt.tick} <= 2'b10;
      #1 `CHK({match, zero_evt}, 3'b000)
      rd(FL, 32'h00000200);
      stop_test();
   end
endmodule
